// ==== core/swac_pkg.sv ====
package swac_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_TAD = 8'h21;
  localparam logic [7:0] IDX_CAL_EN = 8'h22;
  localparam logic [7:0] IDX_CAL_CFG = 8'h23;
  localparam logic [7:0] IDX_CAL_STAT = 8'h24;
  localparam logic [7:0] IDX_POS_LO = 8'h2c;
  localparam logic [7:0] IDX_POS_MID = 8'h2d;
  localparam logic [7:0] IDX_POS_HI = 8'h2e;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam int CTRL_FINE_BIT = 4;
  localparam logic CTRL_FINE_RST = 1'b1;
  localparam int CAL_EN_BIT = 0;

  // delay setting layout, shared by the tad register and the result field
  localparam int DLY_W = 8;
  localparam int APERTURE_DELAY_FINE_LSB = 0;
  localparam int APERTURE_DELAY_COARSE_LSB = 8;
  localparam int CLOCK_HALF_PERIOD_INVERT_BIT = 16;

  // calibration config fields
  localparam int CFG_SETTLE_LSB = 0;
  localparam int CFG_FINE_LSB = 8;
  localparam logic [7:0] CFG_SETTLE_RST = 8'h10;
  localparam logic [7:0] CFG_FINE_RST = 8'h00;

  // calibration status fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_RES_LSB = 8;

  // position detector
  localparam int NPOS = 24;
  localparam int BYTE_W = 8;
  localparam int EDGE_W = 2;
  localparam logic [1:0] EDGES_VALID = 2'h3;
  localparam logic [7:0] COARSE_MAX = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_APPLY,
    ST_SETTLE,
    ST_WAIT_EDGE,
    ST_DONE
  } swac_state_t;
endpackage

// ==== core/swac_edge_count.sv ====
`timescale 1ns/100ps
// saturating event counter, restarts on clear
module swac_edge_count #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic event_in,
  // count
  output logic [W-1:0] count
);
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;

  // hold at all ones so the count never wraps back to invalid
  always_comb
  begin
    nxt_count = count_ff;
    if (clear)
      nxt_count = '0;
    else if (event_in && (count_ff != {W{1'b1}}))
      nxt_count = count_ff + W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_ff <= '0;
    else
      count_ff <= nxt_count;
  end

  assign count = count_ff;
endmodule // swac_edge_count

// ==== core/swac_top.sv ====
`timescale 1ns/100ps
module swac_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [swac_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sysref and its delayed tap captures
  input wire logic sysref,
  input wire logic [swac_pkg::NPOS-1:0] tap_capture,
  input wire logic sysref_phase_late,
  // to the analog delay cells and sysref capture
  output logic window_step_fine,
  output logic clock_half_period_invert,
  output logic [swac_pkg::DLY_W-1:0] aperture_delay_coarse,
  output logic [swac_pkg::DLY_W-1:0] aperture_delay_fine,
  output logic sysref_captured
);
  localparam int N = swac_pkg::NPOS;
  localparam int DW = swac_pkg::DLY_W;

  // register state
  logic [swac_pkg::SEL_W-1:0] capture_point_select_ff;
  logic step_fine_ff;
  logic clock_half_period_invert_ff;
  logic [DW-1:0] aperture_delay_coarse_ff;
  logic [DW-1:0] aperture_delay_fine_ff;
  logic align_cal_enable_ff;
  logic [DW-1:0] cfg_settle_ff;
  logic [DW-1:0] cfg_fine_ff;
  logic [31:0] prdata_ff;
  // detector state
  logic sysref_d_ff;
  logic [N-1:0] flags_acc_ff;
  logic sysref_captured_ff;
  logic [swac_pkg::EDGE_W-1:0] edge_count;
  // calibration state
  swac_pkg::swac_state_t state_ff;
  logic enable_d_ff;
  logic align_cal_done_ff;
  logic cand_inv_ff;
  logic [DW-1:0] cand_coarse_ff;
  logic [DW-1:0] settle_ff;
  logic best_inv_ff;
  logic [DW-1:0] best_coarse_ff;
  logic load_result_ff;

  logic sysref_rise;
  logic fine_change;
  logic flags_valid;
  logic [N-1:0] boundary;
  logic [N-1:0] capture_window_flags;
  logic [7:0] idx;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic cal_start;
  logic cal_busy;
  logic [31:0] rd_mux;
  logic [31:0] align_cal_result;

  assign idx = paddr[swac_pkg::IDX_LSB +: 8];
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign sysref_rise = sysref && !sysref_d_ff;
  assign cal_start = align_cal_enable_ff && !enable_d_ff;
  assign cal_busy = (state_ff != swac_pkg::ST_IDLE) && (state_ff != swac_pkg::ST_DONE);
  assign fine_change = wr_en && (idx == swac_pkg::IDX_CTRL)
                       && (pwdata[swac_pkg::CTRL_FINE_BIT] != step_fine_ff);

  // address decode for the error answer only; the read mux decodes idx on its own
  always_comb
  begin
    case (idx)
      swac_pkg::IDX_CTRL, swac_pkg::IDX_TAD, swac_pkg::IDX_CAL_EN,
      swac_pkg::IDX_CAL_CFG, swac_pkg::IDX_CAL_STAT, swac_pkg::IDX_POS_LO,
      swac_pkg::IDX_POS_MID, swac_pkg::IDX_POS_HI: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // no wait states; unmapped accesses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;

  // software registers; apb write wins over the result load
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capture_point_select_ff <= '0;
      step_fine_ff <= swac_pkg::CTRL_FINE_RST;
      align_cal_enable_ff <= 1'b0;
      cfg_settle_ff <= swac_pkg::CFG_SETTLE_RST;
      cfg_fine_ff <= swac_pkg::CFG_FINE_RST;
    end
    else if (wr_en)
    begin
      case (idx)
        swac_pkg::IDX_CTRL:
        begin
          // selector is 4 bits wide so only taps 0 to 15 are reachable
          capture_point_select_ff <= pwdata[swac_pkg::CTRL_SEL_LSB +: swac_pkg::SEL_W];
          step_fine_ff <= pwdata[swac_pkg::CTRL_FINE_BIT];
        end
        swac_pkg::IDX_CAL_EN: align_cal_enable_ff <= pwdata[swac_pkg::CAL_EN_BIT];
        swac_pkg::IDX_CAL_CFG:
        begin
          cfg_settle_ff <= pwdata[swac_pkg::CFG_SETTLE_LSB +: DW];
          cfg_fine_ff <= pwdata[swac_pkg::CFG_FINE_LSB +: DW];
        end
        default: ;
      endcase
    end
  end

  // delay register: kept after calibration until software rewrites it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_half_period_invert_ff <= 1'b0;
      aperture_delay_coarse_ff <= '0;
      aperture_delay_fine_ff <= '0;
    end
    else if (wr_en && (idx == swac_pkg::IDX_TAD))
    begin
      clock_half_period_invert_ff <= pwdata[swac_pkg::CLOCK_HALF_PERIOD_INVERT_BIT];
      aperture_delay_coarse_ff <= pwdata[swac_pkg::APERTURE_DELAY_COARSE_LSB +: DW];
      aperture_delay_fine_ff <= pwdata[swac_pkg::APERTURE_DELAY_FINE_LSB +: DW];
    end
    else if (load_result_ff)
    begin
      clock_half_period_invert_ff <= best_inv_ff;
      aperture_delay_coarse_ff <= best_coarse_ff;
      aperture_delay_fine_ff <= cfg_fine_ff;
    end
  end

  // the search drives the delay cells directly while it runs
  assign clock_half_period_invert = cal_busy ? cand_inv_ff : clock_half_period_invert_ff;
  assign aperture_delay_coarse = cal_busy ? cand_coarse_ff : aperture_delay_coarse_ff;
  assign aperture_delay_fine = cal_busy ? cfg_fine_ff : aperture_delay_fine_ff;
  assign window_step_fine = step_fine_ff;

  always_comb
  begin
    align_cal_result = '0;
    align_cal_result[swac_pkg::STAT_DONE_BIT] = align_cal_done_ff;
    align_cal_result[swac_pkg::STAT_VALID_BIT] = flags_valid;
    align_cal_result[swac_pkg::STAT_BUSY_BIT] = cal_busy;
    align_cal_result[swac_pkg::STAT_RES_LSB + swac_pkg::APERTURE_DELAY_FINE_LSB +: DW] = aperture_delay_fine_ff;
    align_cal_result[swac_pkg::STAT_RES_LSB + swac_pkg::APERTURE_DELAY_COARSE_LSB +: DW] = best_coarse_ff;
    align_cal_result[swac_pkg::STAT_RES_LSB + swac_pkg::CLOCK_HALF_PERIOD_INVERT_BIT] = best_inv_ff;
  end

  // read mux; unused bits read as zero
  always_comb
  begin
    rd_mux = '0;
    case (idx)
      swac_pkg::IDX_CTRL:
      begin
        rd_mux[swac_pkg::CTRL_SEL_LSB +: swac_pkg::SEL_W] = capture_point_select_ff;
        rd_mux[swac_pkg::CTRL_FINE_BIT] = step_fine_ff;
      end
      swac_pkg::IDX_TAD:
      begin
        rd_mux[swac_pkg::CLOCK_HALF_PERIOD_INVERT_BIT] = clock_half_period_invert_ff;
        rd_mux[swac_pkg::APERTURE_DELAY_COARSE_LSB +: DW] = aperture_delay_coarse_ff;
        rd_mux[swac_pkg::APERTURE_DELAY_FINE_LSB +: DW] = aperture_delay_fine_ff;
      end
      swac_pkg::IDX_CAL_EN: rd_mux[swac_pkg::CAL_EN_BIT] = align_cal_enable_ff;
      swac_pkg::IDX_CAL_CFG:
      begin
        rd_mux[swac_pkg::CFG_SETTLE_LSB +: DW] = cfg_settle_ff;
        rd_mux[swac_pkg::CFG_FINE_LSB +: DW] = cfg_fine_ff;
      end
      swac_pkg::IDX_CAL_STAT: rd_mux = align_cal_result;
      swac_pkg::IDX_POS_LO: rd_mux[swac_pkg::BYTE_W-1:0] = capture_window_flags[7:0];
      swac_pkg::IDX_POS_MID: rd_mux[swac_pkg::BYTE_W-1:0] = capture_window_flags[15:8];
      swac_pkg::IDX_POS_HI: rd_mux[swac_pkg::BYTE_W-1:0] = capture_window_flags[23:16];
      default: rd_mux = '0;
    endcase
  end

  // read data sampled in the setup cycle, stable through the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (rd_setup)
      prdata_ff <= rd_mux;
  end

  // sysref edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sysref_d_ff <= 1'b0;
    else
      sysref_d_ff <= sysref;
  end

  // a tap whose capture differs from a neighbour sits in the transition
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_tap
      if ((g == 0) || (g == N - 1))
      begin : g_end
        assign boundary[g] = 1'b1;
      end
      else
      begin : g_mid
        assign boundary[g] = (tap_capture[g] != tap_capture[g-1])
                             || (tap_capture[g] != tap_capture[g+1]);
      end
    end
  endgenerate

  // edges are counted again whenever the tap spacing moves
  swac_edge_count #(
    .W(swac_pkg::EDGE_W)
  ) u_edges (
    .pclk(pclk),
    .presetn(presetn),
    .clear(fine_change),
    .event_in(sysref_rise),
    .count(edge_count)
  );

  assign flags_valid = (edge_count >= swac_pkg::EDGES_VALID);
  // flags read zero until enough edges have been seen
  assign capture_window_flags = flags_valid ? flags_acc_ff : '0;

  // sticky risk flags; any edge that shows a boundary marks the tap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_acc_ff <= '0;
    else if (fine_change)
      flags_acc_ff <= '0;
    else if (sysref_rise)
      flags_acc_ff <= flags_acc_ff | boundary;
  end

  // sysref taken at the selected tap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sysref_captured_ff <= 1'b0;
    else
      sysref_captured_ff <= tap_capture[{1'b0, capture_point_select_ff}];
  end
  assign sysref_captured = sysref_captured_ff;

  // enable history for start detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_d_ff <= 1'b0;
    else
      enable_d_ff <= align_cal_enable_ff;
  end

  // alignment search; relies on sysref running, a lost sysref stalls it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= swac_pkg::ST_IDLE;
      cand_inv_ff <= 1'b0;
      cand_coarse_ff <= '0;
      settle_ff <= '0;
      best_inv_ff <= 1'b0;
      best_coarse_ff <= '0;
      load_result_ff <= 1'b0;
    end
    else
    begin
      load_result_ff <= 1'b0;
      if (cal_start)
      begin
        state_ff <= swac_pkg::ST_APPLY;
        cand_inv_ff <= 1'b0;
        cand_coarse_ff <= '0;
      end
      else if (!align_cal_enable_ff)
        state_ff <= swac_pkg::ST_IDLE;
      else
      begin
        case (state_ff)
          swac_pkg::ST_APPLY:
          begin
            settle_ff <= cfg_settle_ff;
            state_ff <= swac_pkg::ST_SETTLE;
          end
          swac_pkg::ST_SETTLE:
          begin
            // give the delay cells time before judging the phase
            if (settle_ff == '0)
              state_ff <= swac_pkg::ST_WAIT_EDGE;
            else
              settle_ff <= settle_ff - DW'(1);
          end
          swac_pkg::ST_WAIT_EDGE:
          begin
            if (sysref_rise)
            begin
              if (!sysref_phase_late || (cand_coarse_ff == swac_pkg::COARSE_MAX))
              begin
                // falling edge reached sysref, or the range ran out
                if (!cand_inv_ff)
                begin
                  best_inv_ff <= 1'b0;
                  best_coarse_ff <= cand_coarse_ff;
                  cand_inv_ff <= 1'b1;
                  cand_coarse_ff <= '0;
                  state_ff <= swac_pkg::ST_APPLY;
                end
                else
                begin
                  // smaller coarse delay means less clock path loss
                  if (cand_coarse_ff < best_coarse_ff)
                  begin
                    best_inv_ff <= 1'b1;
                    best_coarse_ff <= cand_coarse_ff;
                  end
                  load_result_ff <= 1'b1;
                  state_ff <= swac_pkg::ST_DONE;
                end
              end
              else
              begin
                cand_coarse_ff <= cand_coarse_ff + DW'(1);
                state_ff <= swac_pkg::ST_APPLY;
              end
            end
          end
          swac_pkg::ST_DONE: state_ff <= swac_pkg::ST_DONE;
          swac_pkg::ST_IDLE: state_ff <= swac_pkg::ST_IDLE;
          default: state_ff <= swac_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // done flag: set on finish, cleared by a new start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      align_cal_done_ff <= 1'b0;
    else if (load_result_ff)
      align_cal_done_ff <= 1'b1;
    else if (cal_start)
      align_cal_done_ff <= 1'b0;
  end
endmodule // swac_top

// ==== verification/swac_top_sva.sv ====
`timescale 1ns/100ps
// port-level checker of the alignment block
module swac_top_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [swac_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sysref side
  input wire logic sysref,
  input wire logic [swac_pkg::NPOS-1:0] tap_capture,
  input wire logic sysref_phase_late,
  // delay and capture outputs
  input wire logic window_step_fine,
  input wire logic clock_half_period_invert,
  input wire logic [swac_pkg::DLY_W-1:0] aperture_delay_coarse,
  input wire logic [swac_pkg::DLY_W-1:0] aperture_delay_fine,
  input wire logic sysref_captured
);
  logic [7:0] idx;
  logic acc;
  logic wr_acc;
  logic mapped;
  logic [16:0] dly;
  logic [3:0] sel_ff;
  logic cap_exp_ff;
  logic cal_en_ff;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access decode, index from the word address
  assign idx = paddr[9:2];
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign mapped = (idx >= swac_pkg::IDX_CTRL && idx <= swac_pkg::IDX_CAL_STAT) ||
    (idx >= swac_pkg::IDX_POS_LO && idx <= swac_pkg::IDX_POS_HI);
  assign dly = {clock_half_period_invert, aperture_delay_coarse, aperture_delay_fine};
  // shadow of selector and enable, kept from bus writes only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_ff <= 4'h0;
      cal_en_ff <= 1'b0;
      cap_exp_ff <= 1'b0;
    end
    else
    begin
      cap_exp_ff <= tap_capture[sel_ff];
      if (wr_acc && idx == swac_pkg::IDX_CTRL)
        sel_ff <= pwdata[3:0];
      if (wr_acc && idx == swac_pkg::IDX_CAL_EN)
        cal_en_ff <= pwdata[0];
    end
  end
  chk_ready_const: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  chk_fine_write: assert property (
    wr_acc && idx == swac_pkg::IDX_CTRL |=> window_step_fine == $past(pwdata[4]))
    else $error("step fine not taken from write");
  chk_fine_hold: assert property (
    !(wr_acc && idx == swac_pkg::IDX_CTRL) |=> $stable(window_step_fine))
    else $error("step fine moved without write");
  chk_capture_sel: assert property (sysref_captured == cap_exp_ff)
    else $error("capture not from selected tap");
  chk_tad_write: assert property (
    wr_acc && idx == swac_pkg::IDX_TAD && !cal_en_ff |=>
    dly == {$past(pwdata[16]), $past(pwdata[15:8]), $past(pwdata[7:0])})
    else $error("written delay not applied");
  chk_delay_hold: assert property (
    !cal_en_ff && !(wr_acc && (idx == swac_pkg::IDX_TAD || idx == swac_pkg::IDX_CAL_EN))
    |=> $stable(dly))
    else $error("delay moved while idle");
  chk_prdata_stands: assert property (acc && !pwrite |=> $stable(prdata))
    else $error("read data did not stand");
  chk_flag_ends: assert property (
    acc && !pwrite && prdata != 32'h0 &&
    (idx == swac_pkg::IDX_POS_LO || idx == swac_pkg::IDX_POS_HI) |->
    (idx == swac_pkg::IDX_POS_LO ? prdata[0] : prdata[7]))
    else $error("end flag not set");
  cov_cal_start: cover property (wr_acc && idx == swac_pkg::IDX_CAL_EN && pwdata[0]);
  cov_inv_search: cover property (cal_en_ff && clock_half_period_invert);
  cov_unmapped: cover property (acc && pslverr);
endmodule // swac_top_sva

bind swac_top swac_top_sva swac_top_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sysref(sysref), .tap_capture(tap_capture),
  .sysref_phase_late(sysref_phase_late), .window_step_fine(window_step_fine),
  .clock_half_period_invert(clock_half_period_invert),
  .aperture_delay_coarse(aperture_delay_coarse), .aperture_delay_fine(aperture_delay_fine),
  .sysref_captured(sysref_captured));

// ==== verification/swac_clk_src_model.sv ====
`timescale 1ns/100ps
// system clock source: periodic sysref, tap captures, phase detector
module swac_clk_src_model #(
  parameter int PERIOD = 16,
  parameter int HIGH = 4,
  parameter logic [7:0] ALIGN_PLAIN = 8'h14,
  parameter logic [7:0] ALIGN_INV = 8'h06
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // delay setting from the device
  input wire logic clock_half_period_invert,
  input wire logic [swac_pkg::DLY_W-1:0] aperture_delay_coarse,
  // sysref side
  output logic sysref,
  output logic [swac_pkg::NPOS-1:0] tap_capture,
  output logic sysref_phase_late
);
  int phase_ff;
  // sysref never pauses, a calibration may start at any time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_ff <= 0;
    else
      phase_ff <= (phase_ff == PERIOD - 1) ? 0 : phase_ff + 1;
  end
  assign sysref = (phase_ff >= PERIOD - HIGH);
  // short taps see the edge, long ones miss it: one transition region
  assign tap_capture = sysref ? 24'h0003ff : 24'h000000;
  // inverted clock needs less coarse delay, so the search must prefer it
  assign sysref_phase_late = aperture_delay_coarse <
    (clock_half_period_invert ? ALIGN_INV : ALIGN_PLAIN);
endmodule // swac_clk_src_model

// ==== verification/swac_tb_top.sv ====
`timescale 1ns/100ps
module swac_tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [swac_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sysref;
  logic [swac_pkg::NPOS-1:0] tap_capture;
  logic sysref_phase_late;
  logic window_step_fine;
  logic clock_half_period_invert;
  logic [swac_pkg::DLY_W-1:0] aperture_delay_coarse;
  logic [swac_pkg::DLY_W-1:0] aperture_delay_fine;
  logic sysref_captured;
  int n_fail;
  int total_checks;
  swac_top swac_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysref(sysref), .tap_capture(tap_capture),
    .sysref_phase_late(sysref_phase_late), .window_step_fine(window_step_fine),
    .clock_half_period_invert(clock_half_period_invert),
    .aperture_delay_coarse(aperture_delay_coarse), .aperture_delay_fine(aperture_delay_fine),
    .sysref_captured(sysref_captured));
  swac_clk_src_model swac_clk_src_model_i (.pclk(pclk), .presetn(presetn),
    .clock_half_period_invert(clock_half_period_invert),
    .aperture_delay_coarse(aperture_delay_coarse), .sysref(sysref),
    .tap_capture(tap_capture), .sysref_phase_late(sysref_phase_late));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, then one idle edge so back to back calls never collide
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: a slave that never answers is caught by the watchdog
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
    input logic [31:0] m = 32'hffffffff);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r & m, exp);
  endtask
  // poll status until done, bounded so a stuck search shows up
  task automatic wait_done();
    logic [31:0] r;
    logic e;
    int n;
    r = 32'h0;
    n = 0;
    while (r[0] !== 1'b1 && n < 400)
    begin
      apb(1'b0, swac_pkg::IDX_CAL_STAT, 32'h0, r, e);
      n++;
    end
    chk(r & 32'h5, 32'h1);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(swac_pkg::IDX_POS_LO, 32'h0);
    chk({31'h0, window_step_fine}, 32'h1);
    rd(swac_pkg::IDX_CTRL, 32'h10);
    rd(swac_pkg::IDX_CAL_CFG, 32'h10);
    rd(swac_pkg::IDX_TAD, 32'h0);
    apb(1'b0, 8'h3f, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask
  task automatic t_flags();
    repeat (60) @(posedge pclk);
    rd(swac_pkg::IDX_POS_LO, 32'h01);
    rd(swac_pkg::IDX_POS_MID, 32'h06);
    rd(swac_pkg::IDX_POS_HI, 32'h80);
    wr(swac_pkg::IDX_CTRL, 32'h0);
    chk({31'h0, window_step_fine}, 32'h0);
    rd(swac_pkg::IDX_POS_LO, 32'h0);
    wr(swac_pkg::IDX_CTRL, 32'h10);
    chk({31'h0, window_step_fine}, 32'h1);
  endtask
  // capture follows the selected tap on a sysref high cycle
  task automatic t_select();
    logic [3:0] s [4] = '{4'h9, 4'ha, 4'hf, 4'h0};
    foreach (s[i])
    begin
      wr(swac_pkg::IDX_CTRL, {27'h0, 1'b1, s[i]});
      @(negedge pclk);
      for (int n = 0; n < 40 && sysref !== 1'b1; n++)
        @(negedge pclk);
      @(posedge pclk);
      #1;
      chk({31'h0, sysref_captured}, {31'h0, s[i] < 4'ha});
      @(posedge pclk);
    end
  endtask
  task automatic t_cal();
    wr(swac_pkg::IDX_CTRL, 32'h10);
    wr(swac_pkg::IDX_CAL_CFG, 32'h3502);
    wr(swac_pkg::IDX_CAL_EN, 32'h1);
    rd(swac_pkg::IDX_CAL_STAT, 32'h4, 32'h5);
    wait_done();
    rd(swac_pkg::IDX_CAL_STAT, 32'h01063503);
    chk({15'h0, clock_half_period_invert, aperture_delay_coarse, aperture_delay_fine},
      32'h10635);
    repeat (100) @(posedge pclk);
    rd(swac_pkg::IDX_TAD, 32'h10635);
    wr(swac_pkg::IDX_CAL_STAT, 32'h0);
    rd(swac_pkg::IDX_CAL_STAT, 32'h01063503);
  endtask
  task automatic t_manual();
    wr(swac_pkg::IDX_CAL_EN, 32'h0);
    wr(swac_pkg::IDX_TAD, 32'h00000a0b);
    chk({15'h0, clock_half_period_invert, aperture_delay_coarse, aperture_delay_fine},
      32'h00a0b);
    wr(swac_pkg::IDX_CAL_EN, 32'h1);
    rd(swac_pkg::IDX_CAL_STAT, 32'h4, 32'h5);
    wait_done();
    wr(swac_pkg::IDX_CAL_EN, 32'h0);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // watchdog far beyond the two searches
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    complete_run();
  end
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_flags();
    t_select();
    t_cal();
    t_manual();
    complete_run();
  end
endmodule // swac_tb_top
